// file: design/lane_fabric_flywheel_fifo.sv
// Lane boundary between the PMA/PCS side and fabric logic, with AXI4-Lite control.
// Assumes one clock; lane clocks arrive and leave as one-cycle tick strobes on it.
`timescale 1ns/100ps
`include "lane_fabric_map.svh"

module lane_fabric_flywheel_fifo (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  input  wire logic [`LF_ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  output logic      [1:0]            s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  input  wire logic [`LF_ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output logic      [31:0]           s_axi_rdata_o,
  output logic      [1:0]            s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  input  wire logic                  synth_tick_i,
  input  wire logic                  recov_tick_i,
  input  wire logic                  rate_match_tick_i,
  input  wire logic                  tx_wclk_tick_i,
  input  wire logic [`LF_DATA_W-1:0] fab_tx_data_i,
  input  wire logic [`LF_DATA_W-1:0] pma_rx_data_i,
  output logic                       tx_clk_tick_o,
  output logic                       glob_clk_tick_o,
  output logic                       rx_clk_tick_o,
  output logic                       pma_tx_strobe_o,
  output logic      [`LF_DATA_W-1:0] pma_tx_data_o,
  output logic                       fab_rx_strobe_o,
  output logic      [`LF_DATA_W-1:0] fab_rx_data_o
);
  import lane_fabric_pkg::*;

  logic [7:0]            ctrl;
  logic [`LF_ERR_W-1:0]  err;
  logic                  recenter;
  wr_state_t             wr_state;
  logic                  aw_held;
  logic                  w_held;
  logic [`LF_ADDR_W-1:0] aw_addr;
  logic [31:0]           w_data;
  logic [3:0]            w_strb;

  logic                  tmg_det;
  clk_res_t              res;
  gear_t                 gear;
  logic                  geared;
  logic                  tx_half;
  logic                  rx_half;
  logic                  tx_tick;
  logic                  rx_src;
  logic                  rx_tick;
  logic                  tx_wr;
  logic                  tx_rd_d;
  logic                  rx_rd_d;
  logic [`LF_DATA_W-1:0] tx_stage;
  logic [`LF_DATA_W-1:0] rx_stage;
  logic [`LF_DATA_W-1:0] tx_fifo_in;
  logic [`LF_DATA_W-1:0] tx_fifo_q;
  logic [`LF_DATA_W-1:0] rx_fifo_q;
  fill_t                 tx_level;
  fill_t                 rx_level;
  logic                  tx_ovf;
  logic                  tx_udf;
  logic                  rx_ovf;
  logic                  rx_udf;
  logic                  fifo_on;
  logic [`LF_ERR_W-1:0]  err_set;
  logic [`LF_ERR_W-1:0]  err_clr;
  logic                  wr_fire;
  reg_sel_t              wr_sel;

  function automatic reg_sel_t decode(input logic [`LF_ADDR_W-1:0] addr);
    case (addr)
      `LF_CTRL_OFS: decode = SEL_CTRL;
      `LF_STAT_OFS: decode = SEL_STAT;
      `LF_INFO_OFS: decode = SEL_INFO;
      default:      decode = SEL_NONE;
    endcase
  endfunction

  function automatic logic gear_on(input gear_t g);
    case (g)
      GEAR_8B10B_8OCT, GEAR_WIDE_BLOCK, GEAR_PMA64, GEAR_PMA80: gear_on = 1'b1;
      default: gear_on = 1'b0;
    endcase
  endfunction

  // Control fields
  assign tmg_det = ctrl[`LF_CTRL_TMG];
  assign res     = clk_res_t'(ctrl[`LF_CTRL_RES_HI:`LF_CTRL_RES_LO]);
  assign gear    = gear_t'(ctrl[`LF_CTRL_GEAR_HI:`LF_CTRL_GEAR_LO]);
  assign geared  = gear_on(gear);
  assign fifo_on = (res != RES_DET_REG);

  // Lane tick generation with optional 1:2 gearing
  assign tx_tick = synth_tick_i && (!geared || tx_half);
  assign rx_src  = ctrl[`LF_CTRL_RXSEL] ? rate_match_tick_i : recov_tick_i;
  assign rx_tick = rx_src && (!geared || rx_half);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || recenter) begin
      tx_half <= 1'b0;
      rx_half <= 1'b0;
    end else begin
      if (synth_tick_i) begin
        tx_half <= !tx_half;
      end
      if (rx_src) begin
        rx_half <= !rx_half;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tx_clk_tick_o   <= 1'b0;
      glob_clk_tick_o <= 1'b0;
      rx_clk_tick_o   <= 1'b0;
    end else begin
      tx_clk_tick_o   <= tx_tick;
      glob_clk_tick_o <= tx_tick && ((res == RES_GLOBAL)
                         || (res == RES_SHARED && ctrl[`LF_CTRL_MASTER]));
      rx_clk_tick_o   <= rx_tick;
    end
  end

  // Fabric presents one transmit word on each write tick; shared lanes use the master tick
  assign tx_wr      = (res == RES_SHARED) ? tx_wclk_tick_i : tx_clk_tick_o;
  assign tx_fifo_in = tmg_det ? tx_stage : fab_tx_data_i;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      tx_stage <= '0;
      rx_stage <= '0;
      tx_rd_d  <= 1'b0;
      rx_rd_d  <= 1'b0;
    end else begin
      if (tx_wr) begin
        tx_stage <= fab_tx_data_i;
      end
      if (rx_rd_d) begin
        rx_stage <= rx_fifo_q;
      end
      tx_rd_d <= tx_tick && fifo_on;
      rx_rd_d <= rx_clk_tick_o && fifo_on;
    end
  end

  flywheel_fifo u_tx_fifo (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .recenter_i (recenter),
    .wr_en_i    (tx_wr && fifo_on),
    .wr_data_i  (tx_fifo_in),
    .rd_en_i    (tx_tick && fifo_on),
    .rd_data_o  (tx_fifo_q),
    .level_o    (tx_level),
    .ovf_o      (tx_ovf),
    .udf_o      (tx_udf)
  );

  flywheel_fifo u_rx_fifo (
    .mclk_i     (mclk_i),
    .rst_n_i    (rst_n_i),
    .recenter_i (recenter),
    .wr_en_i    (rx_tick && fifo_on),
    .wr_data_i  (pma_rx_data_i),
    .rd_en_i    (rx_clk_tick_o && fifo_on),
    .rd_data_o  (rx_fifo_q),
    .level_o    (rx_level),
    .ovf_o      (rx_ovf),
    .udf_o      (rx_udf)
  );

  // PMA-side transmit word and fabric-side receive word, one per tick
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pma_tx_data_o   <= '0;
      pma_tx_strobe_o <= 1'b0;
    end else if (!fifo_on) begin
      pma_tx_strobe_o <= tx_wr;
      if (tx_wr) begin
        pma_tx_data_o <= fab_tx_data_i;
      end
    end else begin
      pma_tx_strobe_o <= tx_rd_d;
      if (tx_rd_d) begin
        pma_tx_data_o <= tx_fifo_q;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      fab_rx_data_o   <= '0;
      fab_rx_strobe_o <= 1'b0;
    end else if (!fifo_on) begin
      fab_rx_strobe_o <= rx_tick;
      if (rx_tick) begin
        fab_rx_data_o <= pma_rx_data_i;
      end
    end else begin
      fab_rx_strobe_o <= rx_rd_d;
      if (rx_rd_d) begin
        fab_rx_data_o <= tmg_det ? rx_stage : rx_fifo_q;
      end
    end
  end

  // AXI4-Lite write side: address and data taken in either order
  assign wr_fire = (wr_state == WR_COLLECT) && aw_held && w_held;
  assign wr_sel  = decode(aw_addr);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      wr_state        <= WR_COLLECT;
      aw_held         <= 1'b0;
      w_held          <= 1'b0;
      aw_addr         <= '0;
      w_data          <= '0;
      w_strb          <= '0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o  <= 1'b1;
      s_axi_bvalid_o  <= 1'b0;
      s_axi_bresp_o   <= `LF_RESP_OKAY;
    end else begin
      case (wr_state)
        WR_COLLECT: begin
          if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held         <= 1'b1;
            aw_addr         <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
          end
          if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held         <= 1'b1;
            w_data         <= s_axi_wdata_i;
            w_strb         <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
          end
          if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= (wr_sel == SEL_NONE) ? `LF_RESP_SLVERR : `LF_RESP_OKAY;
            wr_state       <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (s_axi_bready_i) begin
            s_axi_bvalid_o  <= 1'b0;
            aw_held         <= 1'b0;
            w_held          <= 1'b0;
            s_axi_awready_o <= 1'b1;
            s_axi_wready_o  <= 1'b1;
            wr_state        <= WR_COLLECT;
          end
        end
        default: begin
          wr_state <= WR_COLLECT;
        end
      endcase
    end
  end

  // A control write with w_strb[0] set re-centres both FIFOs and the gearing phase
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ctrl     <= `LF_CTRL_RST;
      recenter <= 1'b0;
    end else begin
      recenter <= 1'b0;
      if (wr_fire && wr_sel == SEL_CTRL && w_strb[0]) begin
        ctrl     <= w_data[7:0];
        recenter <= 1'b1;
      end
    end
  end

  // Sticky slip flags, write one to clear; a new slip wins over the clear
  assign err_set = {rx_udf, rx_ovf, tx_udf, tx_ovf};
  assign err_clr = (wr_fire && wr_sel == SEL_STAT && w_strb[1])
                   ? w_data[`LF_STAT_ERR_HI:`LF_STAT_ERR_LO] : '0;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      err <= '0;
    end else begin
      err <= (err & ~err_clr) | err_set;
    end
  end

  // AXI4-Lite read side
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= `LF_RESP_OKAY;
    end else if (s_axi_rvalid_o) begin
      if (s_axi_rready_i) begin
        s_axi_rvalid_o  <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rresp_o   <= `LF_RESP_OKAY;
      s_axi_rdata_o   <= '0;
      case (decode(s_axi_araddr_i))
        SEL_CTRL: begin
          s_axi_rdata_o[7:0] <= ctrl;
        end
        SEL_STAT: begin
          s_axi_rdata_o[`LF_STAT_TXLVL_HI:`LF_STAT_TXLVL_LO] <= tx_level;
          s_axi_rdata_o[`LF_STAT_RXLVL_HI:`LF_STAT_RXLVL_LO] <= rx_level;
          s_axi_rdata_o[`LF_STAT_ERR_HI:`LF_STAT_ERR_LO]     <= err;
        end
        SEL_INFO: begin
          s_axi_rdata_o[`LF_FILL_W-1:0] <= fill_t'(`LF_FIFO_DEPTH);
        end
        default: begin
          s_axi_rresp_o <= `LF_RESP_SLVERR;
        end
      endcase
    end
  end

endmodule

// file: design/lane_fabric_map.svh
// Register offsets, field positions, reset values and sizes of the lane fabric boundary.
// Included by the package and the design files; holds definitions only.
`ifndef LANE_FABRIC_MAP_SVH
`define LANE_FABRIC_MAP_SVH

`define LF_DATA_W        80
`define LF_FIFO_DEPTH    8
`define LF_FIFO_HALF     4
`define LF_PTR_W         3
`define LF_FILL_W        4
`define LF_ADDR_W        8

`define LF_CTRL_OFS      8'h00
`define LF_STAT_OFS      8'h04
`define LF_INFO_OFS      8'h08

`define LF_CTRL_RST      8'h00
`define LF_CTRL_TMG      0
`define LF_CTRL_RES_LO   1
`define LF_CTRL_RES_HI   2
`define LF_CTRL_RXSEL    3
`define LF_CTRL_GEAR_LO  4
`define LF_CTRL_GEAR_HI  6
`define LF_CTRL_MASTER   7

`define LF_STAT_TXLVL_LO 0
`define LF_STAT_TXLVL_HI 3
`define LF_STAT_RXLVL_LO 4
`define LF_STAT_RXLVL_HI 7
`define LF_STAT_ERR_LO   8
`define LF_STAT_ERR_HI   11
`define LF_ERR_W         4
`define LF_ERR_TX_OVF    0
`define LF_ERR_TX_UDF    1
`define LF_ERR_RX_OVF    2
`define LF_ERR_RX_UDF    3

`define LF_RESP_OKAY     2'h0
`define LF_RESP_SLVERR   2'h2

`endif

// file: design/lane_fabric_pkg.sv
// Types shared by the lane fabric boundary and its flywheel FIFO.
// Assumes lane_fabric_map.svh is on the include path.
`include "lane_fabric_map.svh"

package lane_fabric_pkg;

  typedef logic [`LF_FILL_W-1:0] fill_t;

  typedef enum logic [1:0] {
    RES_GLOBAL   = 2'h0,
    RES_SHARED   = 2'h1,
    RES_REGIONAL = 2'h2,
    RES_DET_REG  = 2'h3
  } clk_res_t;

  typedef enum logic [2:0] {
    GEAR_NONE        = 3'h0,
    GEAR_8B10B_8OCT  = 3'h1,
    GEAR_WIDE_BLOCK  = 3'h2,
    GEAR_PMA64       = 3'h3,
    GEAR_PMA80       = 3'h4
  } gear_t;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'h0,
    WR_RESP    = 2'h1
  } wr_state_t;

  typedef enum logic [1:0] {
    SEL_CTRL = 2'h0,
    SEL_STAT = 2'h1,
    SEL_INFO = 2'h3,
    SEL_NONE = 2'h2
  } reg_sel_t;

endpackage

// file: design/flywheel_fifo.sv
// Eight-entry flywheel FIFO; write and read strobes tick at one nominal rate.
// Assumes both strobes come from the single clock and the pointers start half apart.
`timescale 1ns/100ps
`include "lane_fabric_map.svh"

module flywheel_fifo (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_n_i,
  input  wire logic                  recenter_i,
  input  wire logic                  wr_en_i,
  input  wire logic [`LF_DATA_W-1:0] wr_data_i,
  input  wire logic                  rd_en_i,
  output logic      [`LF_DATA_W-1:0] rd_data_o,
  output lane_fabric_pkg::fill_t     level_o,
  output logic                       ovf_o,
  output logic                       udf_o
);
  import lane_fabric_pkg::*;

  logic [`LF_DATA_W-1:0] mem [`LF_FIFO_DEPTH];
  logic [`LF_PTR_W-1:0]  wr_ptr;
  logic [`LF_PTR_W-1:0]  rd_ptr;
  logic                  do_wr;
  logic                  do_rd;
  fill_t                 next_level;

  assign do_rd = rd_en_i && (level_o != fill_t'(0));
  assign do_wr = wr_en_i && ((level_o != fill_t'(`LF_FIFO_DEPTH)) || do_rd);

  always_comb begin
    next_level = level_o;
    if (do_wr && !do_rd) begin
      next_level = fill_t'(level_o + fill_t'(1));
    end else if (do_rd && !do_wr) begin
      next_level = fill_t'(level_o - fill_t'(1));
    end
  end

  // Entries clear on reset so the words ahead of the first real one read as zero
  genvar gi;
  generate
    for (gi = 0; gi < `LF_FIFO_DEPTH; gi++) begin : g_entry
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          mem[gi] <= '0;
        end else if (do_wr && (wr_ptr == `LF_PTR_W'(gi))) begin
          mem[gi] <= wr_data_i;
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i || recenter_i) begin
      wr_ptr  <= `LF_PTR_W'(`LF_FIFO_HALF);
      rd_ptr  <= '0;
      level_o <= fill_t'(`LF_FIFO_HALF);
    end else begin
      if (do_wr) begin
        wr_ptr <= `LF_PTR_W'(wr_ptr + `LF_PTR_W'(1));
      end
      if (do_rd) begin
        rd_ptr <= `LF_PTR_W'(rd_ptr + `LF_PTR_W'(1));
      end
      level_o <= next_level;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rd_data_o <= '0;
    end else if (do_rd) begin
      rd_data_o <= mem[rd_ptr];
    end
  end

  // Slip beyond the phase budget shows as a one-cycle pulse
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      ovf_o <= 1'b0;
      udf_o <= 1'b0;
    end else begin
      ovf_o <= wr_en_i && !do_wr;
      udf_o <= rd_en_i && !do_rd;
    end
  end

endmodule

// file: bench/fabric_model.sv
// Fabric-side model: hands one transmit word to the lane on every write tick.
// Assumes lane ticks are one-cycle strobes on mclk_i.
`timescale 1ns/100ps
module fabric_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        tx_clk_tick_i,
  input  wire logic        glob_clk_tick_i,
  output logic             tx_wclk_tick_o,
  output logic      [79:0] fab_tx_data_o,
  output int               cnt_o
);
  assign tx_wclk_tick_o = glob_clk_tick_i;
  // Word value is the number of the write tick it belongs to
  assign fab_tx_data_o = {48'h0, 32'(cnt_o + 1)};
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cnt_o <= 0;
    end else if (tx_clk_tick_i || tx_wclk_tick_o) begin
      cnt_o <= cnt_o + 1;
    end
  end
endmodule

// file: bench/lane_fabric_sva.sv
// Port-level checks on the lane fabric boundary.
// Assumes one clock and the synchronous active-low reset of the top module.
`timescale 1ns/100ps
module lane_fabric_sva (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        synth_tick_i,
  input wire logic        recov_tick_i,
  input wire logic        rate_match_tick_i,
  input wire logic        tx_clk_tick_o,
  input wire logic        glob_clk_tick_o,
  input wire logic        rx_clk_tick_o,
  input wire logic        pma_tx_strobe_o,
  input wire logic        fab_rx_strobe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  a_tx_tick_src: assert property (tx_clk_tick_o |-> $past(synth_tick_i))
    else $error("transmit tick without synthesizer tick");
  a_rx_tick_src: assert property (rx_clk_tick_o |-> $past(recov_tick_i || rate_match_tick_i))
    else $error("receive tick without source tick");
  a_glob_tick_gate: assert property (glob_clk_tick_o |-> tx_clk_tick_o)
    else $error("global tick not aligned to transmit tick");
  a_pma_read_tick: assert property (pma_tx_strobe_o |-> $past(synth_tick_i, 2))
    else $error("transmit word not timed by synthesizer tick");
  a_fab_rx_timing: assert property (fab_rx_strobe_o |-> $past(rx_clk_tick_o, 2) || rx_clk_tick_o)
    else $error("receive word not timed by receive tick");
  a_wr_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |=> ##1 s_axi_bvalid_o && !s_axi_awready_o)
    else $error("write response late");
  a_wr_resp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o ##0 !s_axi_arready_o)
    else $error("read response late");
  a_rd_data_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
endmodule

bind lane_fabric_flywheel_fifo lane_fabric_sva chk (
  .mclk_i, .rst_n_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o,
  .s_axi_rdata_o, .s_axi_rvalid_o, .s_axi_rready_i, .synth_tick_i, .recov_tick_i,
  .rate_match_tick_i, .tx_clk_tick_o, .glob_clk_tick_o, .rx_clk_tick_o, .pma_tx_strobe_o,
  .fab_rx_strobe_o
);

// file: bench/lane_fabric_flywheel_fifo_tb.sv
// Self-checking bench: AXI4-Lite register access plus lane tick stimulus.
// Assumes the fabric model and the bound checker are compiled before it.
`timescale 1ns/100ps
module lane_fabric_flywheel_fifo_tb;
  import lane_fabric_pkg::*;
  logic        mclk_i = 1'b0, rst_n_i = 1'b0;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i = 4'h0;
  logic        s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic        synth_tick_i = 1'b0, recov_tick_i = 1'b0, rate_match_tick_i = 1'b0;
  logic        tx_wclk_tick_i, tx_clk_tick_o, glob_clk_tick_o, rx_clk_tick_o;
  logic        pma_tx_strobe_o, fab_rx_strobe_o;
  logic [79:0] fab_tx_data_i, pma_rx_data_i = 80'h0, pma_tx_data_o, fab_rx_data_o;
  int          failures = 0, cmp_count = 0, txn = 0, gn = 0, rxn = 0, lat = 0, rlat = 0;
  int          cnt, l0, t0, g0, i;
  logic [7:0]  cv [9] = '{8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h04, 8'h02, 8'h82};
  int          et [9] = '{16, 8, 8, 8, 8, 16, 16, 16, 16};
  int          eg [9] = '{16, 8, 8, 8, 8, 16, 0, 0, 16};

  lane_fabric_flywheel_fifo uut (
    .mclk_i, .rst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .synth_tick_i, .recov_tick_i,
    .rate_match_tick_i, .tx_wclk_tick_i, .fab_tx_data_i, .pma_rx_data_i, .tx_clk_tick_o,
    .glob_clk_tick_o, .rx_clk_tick_o, .pma_tx_strobe_o, .pma_tx_data_o, .fab_rx_strobe_o,
    .fab_rx_data_o
  );
  fabric_model fab (
    .mclk_i, .rst_n_i, .tx_clk_tick_i(tx_clk_tick_o), .glob_clk_tick_i(glob_clk_tick_o),
    .tx_wclk_tick_o(tx_wclk_tick_i), .fab_tx_data_o(fab_tx_data_i), .cnt_o(cnt)
  );

  initial forever #4 mclk_i = ~mclk_i;

  // Tick counts and latency in ticks, from word numbers carried in the data
  always @(posedge mclk_i) begin
    if (tx_clk_tick_o) txn <= txn + 1;
    if (glob_clk_tick_o) gn <= gn + 1;
    if (rx_clk_tick_o) rxn <= rxn + 1;
    if (pma_tx_strobe_o && pma_tx_data_o !== 80'h0) lat <= cnt - int'(pma_tx_data_o[31:0]);
    // Receive count includes a tick standing in the same cycle as the word
    if (fab_rx_strobe_o && fab_rx_data_o !== 80'h0)
      rlat <= rxn + int'(rx_clk_tick_o) - int'(fab_rx_data_o[31:0]);
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw, w, b;
    logic [1:0] r;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    forever begin
      @(negedge mclk_i);
      aw = s_axi_awvalid_i && s_axi_awready_o;
      w = s_axi_wvalid_i && s_axi_wready_o;
      b = s_axi_bvalid_o;
      r = s_axi_bresp_o;
      @(posedge mclk_i);
      if (aw) s_axi_awvalid_i <= 1'b0;
      if (w) s_axi_wvalid_i <= 1'b0;
      if (b) begin
        s_axi_bready_i <= 1'b0;
        break;
      end
    end
    @(posedge mclk_i);
    chk(32'(r), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic at, rt;
    logic [31:0] d;
    logic [1:0] r;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    forever begin
      @(negedge mclk_i);
      at = s_axi_arvalid_i && s_axi_arready_o;
      rt = s_axi_rvalid_o;
      d = s_axi_rdata_o;
      r = s_axi_rresp_o;
      @(posedge mclk_i);
      if (at) s_axi_arvalid_i <= 1'b0;
      if (rt) begin
        s_axi_rready_i <= 1'b0;
        break;
      end
    end
    @(posedge mclk_i);
    chk(d, ed);
    chk(32'(r), 32'(er));
  endtask

  // Mask bit 0 synthesizer, bit 1 recovered, bit 2 rate-matched
  task automatic tick(input int m, input int n, input int g);
    repeat (n) begin
      @(posedge mclk_i);
      synth_tick_i <= m[0];
      recov_tick_i <= m[1];
      rate_match_tick_i <= m[2];
      pma_rx_data_i <= {48'h0, 32'(rxn + 1)};
      @(posedge mclk_i);
      synth_tick_i <= 1'b0;
      recov_tick_i <= 1'b0;
      rate_match_tick_i <= 1'b0;
      repeat (g) @(posedge mclk_i);
    end
    repeat (4) @(posedge mclk_i);
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_i);
    failures++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    rd(8'h08, 32'h8, 2'h0);
    rd(8'h04, 32'h44, 2'h0);
    rd(8'h00, 32'h0, 2'h0);
    rd(8'h0C, 32'h0, 2'h2);
    wr(8'h10, 32'hFF, 4'hF, 2'h2);
    $display("test registers done");
    wr(8'h00, 32'h0, 4'hF, 2'h0);
    tick(1, 12, 1);
    chk(32'(lat >= 3 && lat <= 5), 32'h1);
    l0 = lat;
    wr(8'h00, 32'h1, 4'hF, 2'h0);
    tick(1, 12, 1);
    chk(lat, l0 + 1);
    wr(8'h00, 32'h6, 4'hF, 2'h0);
    tick(1, 6, 1);
    chk(lat, 0);
    wr(8'h00, 32'h0, 4'hF, 2'h0);
    tick(2, 12, 1);
    chk(32'(rlat >= 3 && rlat <= 5), 32'h1);
    wr(8'h00, 32'h6, 4'hF, 2'h0);
    tick(2, 6, 1);
    chk(rlat, 0);
    $display("test latency done");
    for (i = 0; i < 9; i++) begin
      wr(8'h00, {24'h0, cv[i]}, 4'h1, 2'h0);
      t0 = txn;
      g0 = gn;
      tick(1, 16, 1);
      chk(txn - t0, et[i]);
      chk(gn - g0, eg[i]);
    end
    $display("test clocking done");
    for (i = 0; i < 4; i++) begin
      wr(8'h00, {28'h0, i[1], 3'h0}, 4'h1, 2'h0);
      t0 = rxn;
      tick(i[0] ? 4 : 2, 8, 1);
      chk(rxn - t0, (i[0] == i[1]) ? 8 : 0);
    end
    $display("test receive source done");
    wr(8'h00, 32'h2, 4'h1, 2'h0);
    wr(8'h04, 32'hF00, 4'h2, 2'h0);
    tick(1, 6, 1);
    rd(8'h04, 32'h240, 2'h0);
    wr(8'h04, 32'h200, 4'h1, 2'h0);
    rd(8'h04, 32'h240, 2'h0);
    wr(8'h04, 32'h200, 4'h2, 2'h0);
    rd(8'h04, 32'h40, 2'h0);
    $display("test slip flags done");
    stop_test();
  end
endmodule
